// ### rtl/epi_pkg.sv
// package of constants and types for the external pin interrupt unit
package epi_pkg;
	// ------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_PC_GROUP_FLAGS = 8'h1B;
	localparam logic [7:0] IDX_EXT_INT_FLAGS = 8'h1C;
	localparam logic [7:0] IDX_EXT_INT_ENABLE_MASK = 8'h1D;
	localparam logic [7:0] IDX_PC_GROUP_ENABLE = 8'h68;
	localparam logic [7:0] IDX_EXT_INT_SENSE_CONTROL = 8'h69;
	localparam logic [7:0] IDX_PC_MASK_GROUP0 = 8'h6B;
	localparam logic [7:0] IDX_PC_MASK_GROUP1 = 8'h6C;
	localparam logic [7:0] IDX_PC_MASK_GROUP2 = 8'h6D;
	localparam logic [7:0] IDX_PC_MASK_GROUP3 = 8'h73;
	localparam int ADDR_W = 10;
	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int EXT_N = 3;
	localparam int GRP_N = 4;
	localparam int GRP_W = 8;
	localparam int SENSE_W = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic {EPI_BUS_IDLE, EPI_BUS_ACK} epi_bus_state_t;
	typedef struct packed {
		logic [SENSE_W-1:0] sense;
		logic [EXT_N-1:0] ext_en;
		logic [GRP_N-1:0] grp_en;
		logic [GRP_N*GRP_W-1:0] pin_mask;
	} epi_cfg_t;
	typedef struct packed {
		logic [EXT_N-1:0] ext_flag;
		logic [GRP_N-1:0] grp_flag;
	} epi_flags_t;
endpackage

// ### rtl/epi_top.sv
// external pin interrupt unit: dedicated inputs, pin-change groups, register slave
// How it works
// - two-bit sense selects low, any, fall, rise
// - sense register bits 7:6 read zero
// - dedicated request needs global flag and enable
// - edges on dedicated inputs register requests in any, fall and rise modes
// - low level requests while enabled input low
// - mask bits 2:0 enable the dedicated inputs
// - pin activity counts even when pin drives output
// - configured edge sets the dedicated input flag
// - handler entry or written one clears flag
// - flag held clear in low-level mode
// - sleep buffer disable may set flag
// - four group enables in low nibble
// - any unmasked change in enabled group requests
// - group change sets group flag bits 3:0
// - handler entry or written one clears group flag
// - group 3 mask enables pins 31 to 24
// - masks for groups 2, 1, 0 likewise
// - pin changes detected by comparing core clock samples
`timescale 1ns/1ps
module epi_top
	import epi_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [EXT_N-1:0] dedicated_irq_inputs_i,
	input wire logic [GRP_N*GRP_W-1:0] change_detect_pins_i,
	input wire logic global_int_enable_i,
	input wire logic sleep_i,
	input wire logic [EXT_N-1:0] ext_ack_i,
	input wire logic [GRP_N-1:0] grp_ack_i,
	output logic [EXT_N-1:0] ext_req_o,
	output logic [GRP_N-1:0] grp_req_o
);
	// ------------------------------------------------------------
	// bus slave: one wait state per access
	// ------------------------------------------------------------
	epi_bus_state_t bus_state;
	epi_cfg_t cfg;
	epi_flags_t flags;
	logic req;
	logic take;
	logic [7:0] idx;
	logic aligned;
	logic wr_lane0;
	logic [7:0] wbyte;
	logic [7:0] next_rbyte;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & (bus_state == EPI_BUS_IDLE);
	assign take = req & (bus_state == EPI_BUS_ACK);
	assign idx = avs_address_i[ADDR_W-1:2];
	assign aligned = (avs_address_i[1:0] == 2'h0);
	assign wr_lane0 = avs_write_i & take & aligned & avs_byteenable_i[0];
	assign wbyte = avs_writedata_i[7:0];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state <= EPI_BUS_IDLE;
		end else begin
			case (bus_state)
				EPI_BUS_IDLE: begin
					if (req) begin
						bus_state <= EPI_BUS_ACK;
					end
				end
				EPI_BUS_ACK: begin
					bus_state <= EPI_BUS_IDLE;
				end
				default: begin
					bus_state <= EPI_BUS_IDLE;
				end
			endcase
		end
	end

	// unmapped or misaligned reads answer zero
	always_comb begin
		next_rbyte = REG_RESET;
		if (!aligned) begin
			next_rbyte = REG_RESET;
		end else if (idx == IDX_PC_GROUP_FLAGS) begin
			next_rbyte = {4'h0, flags.grp_flag};
		end else if (idx == IDX_EXT_INT_FLAGS) begin
			next_rbyte = {5'h00, flags.ext_flag};
		end else if (idx == IDX_EXT_INT_ENABLE_MASK) begin
			next_rbyte = {5'h00, cfg.ext_en};
		end else if (idx == IDX_PC_GROUP_ENABLE) begin
			next_rbyte = {4'h0, cfg.grp_en};
		end else if (idx == IDX_EXT_INT_SENSE_CONTROL) begin
			next_rbyte = {2'h0, cfg.sense};
		end else if (idx == IDX_PC_MASK_GROUP0) begin
			next_rbyte = cfg.pin_mask[7:0];
		end else if (idx == IDX_PC_MASK_GROUP1) begin
			next_rbyte = cfg.pin_mask[15:8];
		end else if (idx == IDX_PC_MASK_GROUP2) begin
			next_rbyte = cfg.pin_mask[23:16];
		end else if (idx == IDX_PC_MASK_GROUP3) begin
			next_rbyte = cfg.pin_mask[31:24];
		end
	end

	// data is captured in the wait cycle so it stands at the accepting edge
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && bus_state == EPI_BUS_IDLE) begin
			avs_readdata_o <= {24'h00_0000, next_rbyte};
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg <= '0;
		end else if (wr_lane0) begin
			if (idx == IDX_EXT_INT_ENABLE_MASK) begin
				cfg.ext_en <= wbyte[EXT_N-1:0];
			end else if (idx == IDX_PC_GROUP_ENABLE) begin
				cfg.grp_en <= wbyte[GRP_N-1:0];
			end else if (idx == IDX_EXT_INT_SENSE_CONTROL) begin
				cfg.sense <= wbyte[SENSE_W-1:0];
			end else if (idx == IDX_PC_MASK_GROUP0) begin
				cfg.pin_mask[7:0] <= wbyte;
			end else if (idx == IDX_PC_MASK_GROUP1) begin
				cfg.pin_mask[15:8] <= wbyte;
			end else if (idx == IDX_PC_MASK_GROUP2) begin
				cfg.pin_mask[23:16] <= wbyte;
			end else if (idx == IDX_PC_MASK_GROUP3) begin
				cfg.pin_mask[31:24] <= wbyte;
			end
		end
	end

	// ------------------------------------------------------------
	// dedicated inputs
	// ------------------------------------------------------------
	// pins are sampled on the core clock; pins read the same whether
	// driven by the port as outputs or from outside
	logic [EXT_N-1:0] ext_level;
	logic [EXT_N-1:0] ext_prev;
	logic [EXT_N-1:0] ext_hit;
	logic [EXT_N-1:0] ext_is_low;
	logic [EXT_N-1:0] ext_w1c;
	logic [GRP_N-1:0] grp_w1c;

	// a disabled input's buffer is switched off in sleep and reads low,
	// which can look like a falling edge and set its flag
	assign ext_level = dedicated_irq_inputs_i & ~({EXT_N{sleep_i}} & ~cfg.ext_en);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_prev <= '0;
		end else begin
			ext_prev <= ext_level;
		end
	end

	always_comb begin
		ext_hit = '0;
		ext_is_low = '0;
		for (int i = 0; i < EXT_N; i++) begin
			case (cfg.sense[2*i +: 2])
				SENSE_LOW: ext_is_low[i] = 1'h1;
				SENSE_ANY: ext_hit[i] = ext_level[i] ^ ext_prev[i];
				SENSE_FALL: ext_hit[i] = ext_prev[i] & ~ext_level[i];
				SENSE_RISE: ext_hit[i] = ~ext_prev[i] & ext_level[i];
				default: ext_hit[i] = 1'h0;
			endcase
		end
	end

	assign ext_w1c = (wr_lane0 && idx == IDX_EXT_INT_FLAGS) ? wbyte[EXT_N-1:0] : '0;
	assign grp_w1c = (wr_lane0 && idx == IDX_PC_GROUP_FLAGS) ? wbyte[GRP_N-1:0] : '0;

	// a new edge wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags.ext_flag <= '0;
		end else begin
			flags.ext_flag <= ((flags.ext_flag & ~ext_w1c & ~ext_ack_i) | ext_hit)
				& ~ext_is_low;
		end
	end

	// low level requests straight from the pin, so the source must hold it
	assign ext_req_o = ({EXT_N{global_int_enable_i}} & cfg.ext_en)
		& (flags.ext_flag | (ext_is_low & ~ext_level));

	// ------------------------------------------------------------
	// pin-change groups
	// ------------------------------------------------------------
	// the change is compared sample to sample; sleep wake-up is left to
	// the level of the pin, outside this clocked logic
	logic [GRP_N*GRP_W-1:0] pin_prev;
	logic [GRP_N*GRP_W-1:0] pin_change;
	logic [GRP_N-1:0] grp_hit;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_prev <= '0;
		end else begin
			pin_prev <= change_detect_pins_i;
		end
	end

	assign pin_change = (change_detect_pins_i ^ pin_prev) & cfg.pin_mask;

	always_comb begin
		for (int g = 0; g < GRP_N; g++) begin
			grp_hit[g] = cfg.grp_en[g] & (|pin_change[g*GRP_W +: GRP_W]);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags.grp_flag <= '0;
		end else begin
			flags.grp_flag <= (flags.grp_flag & ~grp_w1c & ~grp_ack_i) | grp_hit;
		end
	end

	assign grp_req_o = {GRP_N{global_int_enable_i}} & cfg.grp_en & flags.grp_flag;

	// ------------------------------------------------------------
	// assertions: register bus
	// ------------------------------------------------------------
	// all checks share the core clock and stay quiet while reset is held
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	bus_one_wait_a: assert property (
		req && bus_state == EPI_BUS_IDLE |=> !avs_waitrequest_o || !req)
		else $error("slave did not answer after one wait");
	first_wait_a: assert property (
		req && bus_state == EPI_BUS_IDLE |-> avs_waitrequest_o)
		else $error("request accepted without a wait state");
	read_upper_zero_a: assert property (
		take && avs_read_i |-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bytes not zero");
	sense_top_zero_a: assert property (
		take && avs_read_i && aligned && idx == IDX_EXT_INT_SENSE_CONTROL
		|-> avs_readdata_o[7:6] == 2'h0)
		else $error("sense register top bits not zero");
	enable_write_a: assert property (
		wr_lane0 && idx == IDX_EXT_INT_ENABLE_MASK
		|=> cfg.ext_en == $past(wbyte[EXT_N-1:0]))
		else $error("enable mask write lost");
	group_enable_write_a: assert property (
		wr_lane0 && idx == IDX_PC_GROUP_ENABLE
		|=> cfg.grp_en == $past(wbyte[GRP_N-1:0]))
		else $error("group enable write lost");
	mask3_write_a: assert property (
		wr_lane0 && idx == IDX_PC_MASK_GROUP3
		|=> cfg.pin_mask[31:24] == $past(wbyte))
		else $error("group 3 mask write lost");
	mask0_write_a: assert property (
		wr_lane0 && idx == IDX_PC_MASK_GROUP0
		|=> cfg.pin_mask[7:0] == $past(wbyte))
		else $error("group 0 mask write lost");

	// ------------------------------------------------------------
	// assertions: dedicated inputs
	// ------------------------------------------------------------
	ext_req_gate_a: assert property (
		(ext_req_o & ~({EXT_N{global_int_enable_i}} & cfg.ext_en)) == 3'h0)
		else $error("dedicated request without enable");
	flag_raises_req_a: assert property (
		global_int_enable_i && cfg.ext_en[0] && flags.ext_flag[0] |-> ext_req_o[0])
		else $error("pending flag not requesting");
	low_flag_clear_a: assert property (
		cfg.sense[1:0] == SENSE_LOW && $past(cfg.sense[1:0]) == SENSE_LOW
		|-> !flags.ext_flag[0])
		else $error("flag set in low-level mode");
	low_level_req_a: assert property (
		cfg.sense[1:0] == SENSE_LOW && cfg.ext_en[0] && global_int_enable_i
		&& !ext_level[0] |-> ext_req_o[0])
		else $error("low level not requesting");
	low_release_a: assert property (
		cfg.sense[1:0] == SENSE_LOW && $past(cfg.sense[1:0]) == SENSE_LOW
		&& ext_level[0] |-> !ext_req_o[0])
		else $error("high level still requesting");
	any_sets_flag_a: assert property (
		cfg.sense[1:0] == SENSE_ANY && ext_prev[0] != ext_level[0]
		|=> flags.ext_flag[0] || cfg.sense[1:0] == SENSE_LOW)
		else $error("edge lost in any-edge mode");
	fall_sets_flag_a: assert property (
		cfg.sense[1:0] == SENSE_FALL && ext_prev[0] && !ext_level[0]
		|=> flags.ext_flag[0] || cfg.sense[1:0] == SENSE_LOW)
		else $error("falling edge lost");
	rise_sets_flag_a: assert property (
		cfg.sense[1:0] == SENSE_RISE && !ext_prev[0] && ext_level[0]
		|=> flags.ext_flag[0] || cfg.sense[1:0] == SENSE_LOW)
		else $error("rising edge lost");
	rise_ignored_a: assert property (
		cfg.sense[1:0] == SENSE_RISE && !ext_hit[0] && !flags.ext_flag[0]
		|=> !flags.ext_flag[0])
		else $error("flag set without rising edge");
	// an edge in the same cycle as a clear must still leave the flag set
	edge_wins_a: assert property (
		|ext_hit |=> (flags.ext_flag & $past(ext_hit)) == $past(ext_hit))
		else $error("edge lost to a clear");
	ext_w1c_a: assert property (
		|(ext_w1c & ~ext_hit)
		|=> (flags.ext_flag & $past(ext_w1c & ~ext_hit)) == 3'h0)
		else $error("write one did not clear flag");
	ext_ack_a: assert property (
		|(ext_ack_i & ~ext_hit)
		|=> (flags.ext_flag & $past(ext_ack_i & ~ext_hit)) == 3'h0)
		else $error("acknowledge did not clear flag");
	flag_holds_a: assert property (
		flags.ext_flag[0] && !ext_w1c[0] && !ext_ack_i[0] && !ext_is_low[0]
		|=> flags.ext_flag[0])
		else $error("pending flag dropped on its own");
	sleep_buffer_off_a: assert property (
		sleep_i && !cfg.ext_en[0] |-> !ext_level[0])
		else $error("disabled input not forced low in sleep");

	// ------------------------------------------------------------
	// assertions: pin-change groups
	// ------------------------------------------------------------
	grp_req_gate_a: assert property (
		(grp_req_o & ~({GRP_N{global_int_enable_i}} & cfg.grp_en)) == 4'h0)
		else $error("group request without enable");
	grp_flag_req_a: assert property (
		global_int_enable_i && cfg.grp_en[3] && flags.grp_flag[3] |-> grp_req_o[3])
		else $error("group flag not requesting");
	grp_sets_flag_a: assert property (
		|grp_hit |=> (flags.grp_flag & $past(grp_hit)) == $past(grp_hit))
		else $error("group change lost");
	grp3_set_a: assert property (
		cfg.grp_en[3] && cfg.pin_mask[24] && change_detect_pins_i[24] != pin_prev[24]
		|=> flags.grp_flag[3])
		else $error("group 3 change lost");
	grp_disabled_a: assert property (
		!cfg.grp_en[1] && !flags.grp_flag[1] |=> !flags.grp_flag[1])
		else $error("disabled group set its flag");
	grp_ack_a: assert property (
		|(grp_ack_i & ~grp_hit)
		|=> (flags.grp_flag & $past(grp_ack_i & ~grp_hit)) == 4'h0)
		else $error("acknowledge did not clear group flag");
	grp_w1c_a: assert property (
		|(grp_w1c & ~grp_hit)
		|=> (flags.grp_flag & $past(grp_w1c & ~grp_hit)) == 4'h0)
		else $error("write one did not clear group flag");
	grp_flag_holds_a: assert property (
		flags.grp_flag[0] && !grp_w1c[0] && !grp_ack_i[0]
		|=> flags.grp_flag[0])
		else $error("group flag dropped on its own");
	masked_pin_a: assert property (
		cfg.pin_mask[15:8] == 8'h00 && !flags.grp_flag[1] && !grp_w1c[1]
		##1 cfg.pin_mask[15:8] == 8'h00 |-> !flags.grp_flag[1])
		else $error("masked pins set group flag");

	// ------------------------------------------------------------
	// scenarios worth seeing
	// ------------------------------------------------------------
	edge_any_c: cover property (cfg.sense[1:0] == SENSE_ANY ##1 ext_req_o[0]);
	low_req_c: cover property (ext_req_o[2] && cfg.sense[5:4] == SENSE_LOW);
	grp_req_c: cover property (grp_req_o[0] ##1 grp_ack_i[0]);
	set_clear_c: cover property (ext_hit[0] && ext_w1c[0]);
	sleep_flag_c: cover property (sleep_i && flags.ext_flag[0]);
endmodule // epi_top

// ### tb/epi_core_model.sv
// core-side partner model: enters the handler of a request while allowed
`timescale 1ns/1ps
module epi_core_model
	import epi_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic auto_ack_i,
	input wire logic [EXT_N-1:0] ext_req_i,
	input wire logic [GRP_N-1:0] grp_req_i,
	output logic [EXT_N-1:0] ext_ack_o,
	output logic [GRP_N-1:0] grp_ack_o
);
	// ------------------------------------------------------------
	// handler entry
	// ------------------------------------------------------------
	// one-cycle pulse, then a gap so the flag has cleared before re-entry
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_ack_o <= '0;
			grp_ack_o <= '0;
		end else begin
			ext_ack_o <= auto_ack_i ? (ext_req_i & ~ext_ack_o) : '0;
			grp_ack_o <= auto_ack_i ? (grp_req_i & ~grp_ack_o) : '0;
		end
	end
endmodule // epi_core_model

// ### tb/tb.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module tb
	import epi_pkg::*;
;
	logic core_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [ADDR_W-1:0] addr = '0;
	logic rd_en = 1'h0;
	logic wr_en = 1'h0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic wait_req;
	logic [EXT_N-1:0] dpins = '0;
	logic [GRP_N*GRP_W-1:0] cpins = '0;
	logic gie = 1'h0;
	logic sleep = 1'h0;
	logic auto_ack = 1'h0;
	logic [EXT_N-1:0] ext_ack, ext_req;
	logic [GRP_N-1:0] grp_ack, grp_req;
	logic [31:0] rd;
	int failures = 0;
	int total_checks = 0;
	int waits = 0;
	localparam logic [7:0] IDX_L [10] = '{IDX_PC_GROUP_FLAGS, IDX_EXT_INT_FLAGS,
		IDX_EXT_INT_ENABLE_MASK, IDX_PC_GROUP_ENABLE, IDX_EXT_INT_SENSE_CONTROL,
		IDX_PC_MASK_GROUP0, IDX_PC_MASK_GROUP1, IDX_PC_MASK_GROUP2, IDX_PC_MASK_GROUP3, 8'h20};

	always #10 core_clk_i = ~core_clk_i;

	epi_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_byteenable_i(4'h1),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.dedicated_irq_inputs_i(dpins), .change_detect_pins_i(cpins),
		.global_int_enable_i(gie), .sleep_i(sleep), .ext_ack_i(ext_ack),
		.grp_ack_i(grp_ack), .ext_req_o(ext_req), .grp_req_o(grp_req));
	epi_core_model u_core (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.auto_ack_i(auto_ack), .ext_req_i(ext_req), .grp_req_i(grp_req),
		.ext_ack_o(ext_ack), .grp_ack_o(grp_ack));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// waits for the slave however long it takes; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge core_clk_i);
		addr <= {idx, 2'h0};
		wdata <= {24'h00_0000, d};
		rd_en <= ~wr;
		wr_en <= wr;
		waits = 0;
		@(posedge core_clk_i);
		while (wait_req !== 1'h0) begin
			waits++;
			@(posedge core_clk_i);
		end
		rd = rdata;
		rd_en <= 1'h0;
		wr_en <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'h1, idx, d);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'h0, idx, 8'h00);
		check(rd, {24'h00_0000, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
	task automatic pins(input logic [2:0] d, input logic [31:0] c);
		@(posedge core_clk_i);
		dpins <= d;
		cpins <= c;
		settle(3);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		foreach (IDX_L[i]) rdchk(IDX_L[i], REG_RESET);
		wr(8'h20, 8'hff);
		check(waits, 32'h0000_0001);
		rdchk(8'h20, 8'h00);
		wr(IDX_EXT_INT_SENSE_CONTROL, 8'hff);
		rdchk(IDX_EXT_INT_SENSE_CONTROL, 8'h3f);
		check(waits, 32'h0000_0001);
		$display("test registers done");
	endtask
	task automatic t_edges();
		logic [1:0] m;
		for (int k = 1; k < 4; k++) begin
			m = k[1:0];
			wr(IDX_EXT_INT_ENABLE_MASK, 8'h00);
			wr(IDX_EXT_INT_SENSE_CONTROL, {6'h00, m});
			wr(IDX_EXT_INT_FLAGS, 8'h07);
			pins(3'h1, '0);
			rdchk(IDX_EXT_INT_FLAGS, {7'h00, m != SENSE_FALL});
			wr(IDX_EXT_INT_FLAGS, 8'h01);
			pins(3'h0, '0);
			rdchk(IDX_EXT_INT_FLAGS, {7'h00, m != SENSE_RISE});
			wr(IDX_EXT_INT_FLAGS, 8'h00);
			rdchk(IDX_EXT_INT_FLAGS, {7'h00, m != SENSE_RISE});
		end
		$display("test edges done");
	endtask
	task automatic t_level();
		wr(IDX_EXT_INT_ENABLE_MASK, 8'h00);
		wr(IDX_EXT_INT_SENSE_CONTROL, 8'h00);
		gie <= 1'h1;
		for (int i = 0; i < EXT_N; i++) begin
			wr(IDX_EXT_INT_ENABLE_MASK, 8'h01 << i);
			settle(2);
			check(ext_req, 3'h1 << i);
		end
		rdchk(IDX_EXT_INT_FLAGS, 8'h00);
		gie <= 1'h0;
		settle(1);
		check(ext_req, 3'h0);
		@(posedge core_clk_i);
		gie <= 1'h1;
		pins(3'h4, '0);
		check(ext_req, 3'h0);
		$display("test level done");
	endtask
	task automatic t_ack();
		wr(IDX_EXT_INT_ENABLE_MASK, 8'h00);
		pins(3'h7, '0);
		wr(IDX_EXT_INT_SENSE_CONTROL, 8'h2a);
		wr(IDX_EXT_INT_FLAGS, 8'h07);
		wr(IDX_EXT_INT_ENABLE_MASK, 8'h07);
		pins(3'h2, '0);
		check(ext_req, 3'h5);
		rdchk(IDX_EXT_INT_FLAGS, 8'h05);
		auto_ack <= 1'h1;
		settle(3);
		check(ext_req, 3'h0);
		rdchk(IDX_EXT_INT_FLAGS, 8'h00);
		auto_ack <= 1'h0;
		$display("test acknowledge done");
	endtask
	task automatic t_group();
		wr(IDX_PC_GROUP_ENABLE, 8'h08);
		wr(IDX_PC_MASK_GROUP3, 8'h01);
		pins(dpins, 32'h0200_0000);
		rdchk(IDX_PC_GROUP_FLAGS, 8'h00);
		pins(dpins, 32'h0300_0000);
		check(grp_req, 4'h8);
		rdchk(IDX_PC_GROUP_FLAGS, 8'h08);
		wr(IDX_PC_GROUP_FLAGS, 8'h08);
		rdchk(IDX_PC_GROUP_FLAGS, 8'h00);
		wr(IDX_PC_GROUP_ENABLE, 8'h01);
		wr(IDX_PC_MASK_GROUP0, 8'h80);
		wr(IDX_PC_MASK_GROUP1, 8'hff);
		pins(dpins, 32'h0300_0180);
		rdchk(IDX_PC_GROUP_FLAGS, 8'h01);
		auto_ack <= 1'h1;
		settle(3);
		rdchk(IDX_PC_GROUP_FLAGS, 8'h00);
		auto_ack <= 1'h0;
		$display("test groups done");
	endtask
	task automatic t_sleep();
		wr(IDX_EXT_INT_ENABLE_MASK, 8'h00);
		wr(IDX_EXT_INT_SENSE_CONTROL, 8'h01);
		pins(3'h1, cpins);
		wr(IDX_EXT_INT_FLAGS, 8'h07);
		sleep <= 1'h1;
		settle(3);
		rdchk(IDX_EXT_INT_FLAGS, 8'h01);
		sleep <= 1'h0;
		$display("test sleep done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		t_regs();
		t_edges();
		t_level();
		t_ack();
		t_group();
		t_sleep();
		results();
	end
	// the scenarios need well under two thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk_i);
		failures++;
		results();
	end
endmodule // tb
